// File: bench/ecps_encoder_model.sv
// Behavioural serial position encoder at the far end of the link
`timescale 1ns/1ps
module ecps_encoder_model (
	input  wire logic        i_link_clk, // Link clock from the drive
	input  wire logic [31:0] i_pos,      // Position to report
	input  wire logic [5:0]  i_width,    // Bits per message
	output logic             o_data      // Serial data to the drive
);
	logic [31:0] pos = 32'h0;
	int          idx = 0;
	int          wd  = 1;
	initial o_data = 1'b1;
	// Position is frozen at the first link clock fall of a message
	always @(negedge i_link_clk) begin
		if (idx == 0) begin
			pos = i_pos;
			wd = int'(i_width);
		end
		o_data <= pos[wd - 1 - idx];
		idx = (idx + 1 == wd) ? 0 : idx + 1;
	end
	// A released line shows the inverse of the last bit
	always @(posedge i_link_clk) begin
		if (idx == 0) begin
			o_data <= ~o_data;
		end
	end
endmodule

// File: bench/tb_ecps_setup.sv
// Self-checking testbench of the encoder comms position setup block
`timescale 1ns/1ps
module tb_ecps_setup;
	import ecps_pkg::*;
	logic         i_clk = 0, i_rst = 1, i_de = 0, i_datum = 0, i_wr = 0, i_rd = 0;
	logic [3:0]   i_addr = 4'h0;
	logic [31:0]  i_wdata = 32'h0, mpos = 32'h0, o_rdata;
	logic         lnk, o_link_clk, o_mfr, o_fast;
	logic [5:0]   o_pos_width;
	ecps_supply_t o_supply;
	ecps_trip_t   o_trip;
	ecps_pos_t    o_pos;
	int           miscompares = 0, checked = 0, per = 1000;

	ecps_setup u_ecps_setup (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_drive_enable(i_de),
		.i_datum(i_datum), .i_link_data(lnk), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_link_clk(o_link_clk), .o_supply(o_supply),
		.o_marker_full_reset(o_mfr), .o_fast_sampling(o_fast), .o_trip(o_trip), .o_pos(o_pos),
		.o_pos_width(o_pos_width));
	ecps_encoder_model u_ecps_encoder_model (.i_link_clk(o_link_clk), .i_pos(mpos),
		.i_width(o_pos_width), .o_data(lnk));

	initial begin
		forever #20 i_clk = ~i_clk;
	end
	always begin
		repeat (per - 1) @(posedge i_clk);
		i_datum <= 1'b1;
		@(posedge i_clk);
		i_datum <= 1'b0;
	end
	initial begin
		#3_000_000;
		miscompares++;
		tally_and_finish;
	end

	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		repeat (3) @(negedge i_clk);
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		cmp("read data", e, o_rdata);
	endtask
	task automatic cf(logic [3:0] t, logic [1:0] ro, logic mo, logic [5:0] st, logic [4:0] tu,
		logic [2:0] ra);
		wr(REG_CTRL, 32'({ro, mo, t}));
		wr(REG_ST_BITS, 32'(st));
		wr(REG_TURNS, 32'(tu));
		wr(REG_RATE, 32'(ra));
	endtask
	task automatic ts(logic [3:0] t, logic [5:0] st, logic [4:0] tu, logic [2:0] ra, logic e);
		cf(t, 2'h1, 1'b0, st, tu, ra);
		cmp("fast", 32'(e), 32'(o_fast));
	endtask
	task automatic msg(logic [31:0] e, logic c);
		int n;
		n = 0;
		@(negedge i_clk);
		while (o_pos.valid !== 1'b1 && n < 9000) begin
			@(negedge i_clk);
			n++;
		end
		cmp("valid", 32'h1, 32'(o_pos.valid));
		if (c) cmp("position", e, o_pos.value);
		@(negedge i_clk);
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		cmp("width", 32'h1, 32'(o_pos_width));
		rd(REG_ST_BITS, 32'h0);
		rd(REG_SUPPLY, 32'h0);
		rd(REG_RATE, 32'h2);
		rd(4'hF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(REG_SUPPLY, 32'(i));
			cmp("supply", 32'(1 << (i % 3 + (i / 3) * 2)), 32'(o_supply));
		end
		wr(REG_ST_BITS, 32'h28);
		rd(REG_ST_BITS, 32'h20);
		cmp("marker", 32'h1, 32'(o_mfr));
		wr(REG_ST_BITS, 32'h0);
		cmp("marker", 32'h0, 32'(o_mfr));
		@(posedge i_clk);
		i_de <= 1'b1;
		wr(REG_ST_BITS, 32'h5);
		cmp("marker", 32'h0, 32'(o_mfr));
		@(posedge i_clk);
		i_de <= 1'b0;
		repeat (3) @(negedge i_clk);
		cmp("marker", 32'h1, 32'(o_mfr));
		cf(4'h7, 2'h0, 1'b0, 6'hC, 5'h3, 3'h2);
		cmp("width", 32'h20, 32'(o_pos_width));
		cf(4'hA, 2'h0, 1'b0, 6'hC, 5'h3, 3'h2);
		cmp("width", 32'hC, 32'(o_pos_width));
		cf(4'h9, 2'h2, 1'b0, 6'hC, 5'h4, 3'h2);
		cmp("width", 32'h10, 32'(o_pos_width));
		ts(4'hB, 6'hD, 5'hE, 3'h5, 1'b1);
		ts(4'hB, 6'hE, 5'hE, 3'h5, 1'b0);
		ts(4'h8, 6'h10, 5'h0, 3'h5, 1'b1);
		ts(4'h8, 6'h11, 5'h0, 3'h5, 1'b0);
		ts(4'h8, 6'h2, 5'hA, 3'h4, 1'b1);
		ts(4'h8, 6'h2, 5'hB, 3'h4, 1'b0);
		ts(4'hA, 6'h20, 5'h10, 3'h0, 1'b0);
		cmp("time trip", 32'h0, 32'(o_trip.comms_time));
		ts(4'hB, 6'hD, 5'hC, 3'h0, 1'b0);
		cmp("time trip", 32'h1, 32'(o_trip.comms_time));
		// Position bits include the supply alarm bit
		cf(4'hB, 2'h1, 1'b1, 6'hD, 5'h0, 3'h7);
		wr(REG_STATUS, 32'h6);
		cmp("trips", 32'h0, 32'(o_trip));
		// First datum spacing is measured from reset, so that message only primes
		msg(32'h0, 1'b0);
		mpos = 32'd1000;
		msg(32'd1500, 1'b1);
		mpos = 32'd1201;
		msg(32'd1301, 1'b1);
		repeat (3) @(negedge i_clk);
		cmp("alarm trip", 32'h1, 32'(o_trip.supply_alarm));
		per = 4000;
		mpos = 32'd2000;
		cf(4'hB, 2'h1, 1'b1, 6'hE, 5'h0, 3'h4);
		cmp("fast", 32'h0, 32'(o_fast));
		msg(32'h0, 1'b0);
		msg(32'h0, 1'b0);
		mpos = 32'd2400;
		msg(32'd2775, 1'b1);
		tally_and_finish;
	end
endmodule

// File: common/ecps_pkg.sv
// Constants, register map and carrier types of the encoder comms position setup block
// -------------------------------------------------------------------------------
// -------------------------------------------------------------------------------
package ecps_pkg;
	// -------------------------------------------------------------------------
	// Clock and times
	// -------------------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned PS_PER_US       = 1_000_000;
	localparam longint      PS_PER_S        = 64'd1_000_000_000_000;
	localparam int unsigned T_DATA_PS       = 1_250_000;
	localparam int unsigned T_CAL_PS        = 5_000_000;
	localparam int unsigned CMD_BITS        = 10;
	localparam int unsigned BIDIR_ST_EXTRA  = 2;
	localparam int unsigned BIDIR_MSG_EXTRA = 5;
	localparam int unsigned SYNC_EXTRA      = 1;
	localparam int unsigned FAST_ST_US      = 30;
	localparam int unsigned FAST_MSG_US     = 60;
	localparam int unsigned LIMIT_US        = 160;
	localparam int unsigned LEAD_FAST_US    = 20;
	localparam int unsigned LEAD_SLOW_US    = 150;
	localparam logic [31:0] FAST_ST_PS      = 32'(FAST_ST_US * PS_PER_US);
	localparam logic [31:0] FAST_MSG_PS     = 32'(FAST_MSG_US * PS_PER_US);
	localparam logic [31:0] LIMIT_PS        = 32'(LIMIT_US * PS_PER_US);
	localparam logic [15:0] LEAD_FAST_CYC   = 16'(LEAD_FAST_US * CLK_PER_US);
	localparam logic [15:0] LEAD_SLOW_CYC   = 16'(LEAD_SLOW_US * CLK_PER_US);
	localparam int unsigned ASYNC_BAUD      = 9600;
	localparam int unsigned BAUD_HZ [8]     = '{100_000, 200_000, 300_000, 400_000,
		500_000, 1_000_000, 1_500_000, 2_000_000};
	localparam logic [11:0] ASYNC_HALF      = 12'(CLK_HZ / (2 * ASYNC_BAUD));

	// Bit period in ps, rounded up
	function automatic logic [31:0] ecps_bit_ps(input logic [2:0] sel);
		return 32'((PS_PER_S + longint'(BAUD_HZ[sel]) - 1) / longint'(BAUD_HZ[sel]));
	endfunction

	// Half link clock period in system clocks
	function automatic logic [11:0] ecps_half_cyc(input logic [2:0] sel);
		return 12'(CLK_HZ / (2 * BAUD_HZ[sel]));
	endfunction

	// -------------------------------------------------------------------------
	// Register map and fields
	// -------------------------------------------------------------------------
	localparam logic [3:0] REG_ST_BITS   = 4'h0;
	localparam logic [3:0] REG_SUPPLY    = 4'h1;
	localparam logic [3:0] REG_RATE      = 4'h2;
	localparam logic [3:0] REG_CTRL      = 4'h3;
	localparam logic [3:0] REG_TURNS     = 4'h4;
	localparam logic [3:0] REG_STATUS    = 4'h5;
	localparam logic [3:0] REG_POSITION  = 4'h6;
	localparam int         CTRL_TYPE_LSB = 0;
	localparam int         CTRL_MON_BIT  = 4;
	localparam int         CTRL_ROT_LSB  = 5;
	localparam int         CTRL_AUTO_BIT = 7;
	localparam int         STAT_FAST     = 0;
	localparam int         STAT_TIME     = 1;
	localparam int         STAT_ALARM    = 2;
	localparam int         STAT_BUSY     = 3;
	localparam int         STAT_WID_LSB  = 8;
	localparam logic [5:0] ST_BITS_MIN   = 6'h01;
	localparam logic [5:0] ST_BITS_MAX   = 6'h20;
	localparam logic [5:0] LINEAR_ASYNC_BITS = 6'h20;
	localparam logic [4:0] TURNS_MAX     = 5'h10;
	localparam logic [1:0] SUP_5V        = 2'h0;
	localparam logic [1:0] SUP_8V        = 2'h1;
	localparam logic [1:0] SUP_15V       = 2'h2;
	localparam logic       ALARM_LEVEL   = 1'b1;
	localparam logic [5:0] ST_BITS_RST   = 6'h00;
	localparam logic [1:0] SUPPLY_RST    = 2'h0;
	localparam logic [2:0] RATE_RST      = 3'h2;
	localparam logic [4:0] TURNS_RST     = 5'h00;
	localparam logic [1:0] ROT_RST       = 2'h1;

	// -------------------------------------------------------------------------
	// Types
	// -------------------------------------------------------------------------
	typedef enum logic [3:0] {
		ENC_QUADRATURE_INCREMENTAL          = 4'h0,
		ENC_FREQ_DIRECTION_INCREMENTAL      = 4'h1,
		ENC_FORWARD_REVERSE_INCREMENTAL     = 4'h2,
		ENC_QUADRATURE_WITH_COMMUTATION     = 4'h3,
		ENC_FREQ_DIRECTION_WITH_COMMUTATION = 4'h4,
		ENC_FORWARD_REVERSE_WITH_COMMUTATION = 4'h5,
		ENC_PLAIN_SINE_COSINE               = 4'h6,
		ENC_SINE_COSINE_ASYNC_COMMS         = 4'h7,
		ENC_BIDIR_COMMS_ONLY                = 4'h8,
		ENC_SINE_COSINE_BIDIR_COMMS         = 4'h9,
		ENC_SINE_COSINE_WITH_SYNCHRONOUS_SERIAL = 4'hA,
		ENC_SYNCHRONOUS_SERIAL_ONLY         = 4'hB
	} ecps_enc_t;

	typedef enum logic [1:0] {
		MSG_IDLE = 2'b00,
		MSG_LOW  = 2'b01,
		MSG_HIGH = 2'b11,
		MSG_COMP = 2'b10
	} ecps_msg_t;

	typedef struct packed {
		ecps_enc_t  enc_type;
		logic [1:0] rotary;
		logic       mon_en;
		logic       auto_en;
		logic [5:0] st_bits;
		logic [4:0] turns;
		logic [2:0] rate;
	} ecps_cfg_t;

	typedef struct packed {
		logic v15;
		logic v8;
		logic v5;
	} ecps_supply_t;

	typedef struct packed {
		logic comms_time;
		logic supply_alarm;
	} ecps_trip_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] value;
	} ecps_pos_t;

	localparam ecps_cfg_t CFG_RST = '{enc_type: ENC_QUADRATURE_INCREMENTAL, rotary: ROT_RST,
		mon_en: 1'b0, auto_en: 1'b0, st_bits: ST_BITS_RST, turns: TURNS_RST,
		rate: RATE_RST};
endpackage

// File: src/ecps_div.sv
// Sequential restoring divider used for position delay compensation
`timescale 1ns/1ps
module ecps_div #(
	parameter int NW = 48,
	parameter int DW = 16
) (
	input  wire logic          i_clk,  // System clock
	input  wire logic          i_rst,  // Asynchronous reset
	input  wire logic          i_ce,   // Clock enable
	input  wire logic          i_go,   // Start pulse
	input  wire logic [NW-1:0] i_num,  // Dividend
	input  wire logic [DW-1:0] i_den,  // Divisor, non-zero
	output logic               o_done, // Quotient ready pulse
	output logic [NW-1:0]      o_quo   // Quotient
);
	localparam int CW = $clog2(NW + 1);

	typedef struct packed {
		logic          busy;
		logic          done;
		logic [CW-1:0] cnt;
		logic [DW:0]   rem;
		logic [NW-1:0] quo;
		logic [DW-1:0] den;
	} ecps_div_state_t;

	ecps_div_state_t st;
	ecps_div_state_t next_st;

	always_comb begin
		logic [DW:0] trial;
		trial = {st.rem[DW-1:0], st.quo[NW-1]};
		next_st = st;
		next_st.done = 1'b0;
		if (i_go) begin
			next_st.busy = 1'b1;
			next_st.cnt = CW'(NW);
			next_st.rem = '0;
			next_st.quo = i_num;
			next_st.den = i_den;
		end else if (st.busy) begin
			next_st.quo = {st.quo[NW-2:0], 1'b0};
			if (trial >= {1'b0, st.den}) begin
				next_st.rem = trial - {1'b0, st.den};
				next_st.quo[0] = 1'b1;
			end else begin
				next_st.rem = trial;
			end
			next_st.cnt = st.cnt - 1'b1;
			if (st.cnt == CW'(1)) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_done = st.done;
	assign o_quo  = st.quo;
endmodule

// File: src/ecps_setup.sv
// Encoder comms position setup: settings, timing checks, link sequencing, compensation
`timescale 1ns/1ps
module ecps_setup
	import ecps_pkg::*;
(
	input  wire logic   i_clk,               // System clock, 25 MHz
	input  wire logic   i_rst,               // Asynchronous reset, active high
	input  wire logic   i_ce,                // Clock enable, freezes state when low
	input  wire logic   i_drive_enable,      // Drive enabled level
	input  wire logic   i_datum,             // Control sample datum pulse
	input  wire logic   i_link_data,         // Serial data from encoder
	input  wire logic   [3:0] i_addr,        // Register index
	input  wire logic   [31:0] i_wdata,      // Write data
	input  wire logic   i_wr,                // Write strobe
	input  wire logic   i_rd,                // Read strobe
	output logic        [31:0] o_rdata,      // Read data, cycle after strobe
	output logic        o_link_clk,          // Link clock to encoder
	output ecps_supply_t o_supply,           // Encoder supply select, one-hot
	output logic        o_marker_full_reset, // Marker resets full position
	output logic        o_fast_sampling,     // Fast sampling chosen
	output ecps_trip_t  o_trip,              // Sticky trips
	output ecps_pos_t   o_pos,               // Compensated position
	output logic        [5:0] o_pos_width    // Position bits in message
);
	// -------------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------------
	typedef struct packed {
		ecps_cfg_t   sw;
		ecps_cfg_t   act;
		logic [1:0]  sup;
		logic        fast;
		ecps_trip_t  trip;
		logic [2:0]  sy;
		logic        din;
		logic [15:0] since;
		logic [15:0] period;
		ecps_msg_t   msg;
		logic [11:0] half;
		logic [5:0]  bits;
		logic [31:0] shreg;
		logic [31:0] prev;
		logic        link_clk;
		logic        div_go;
		ecps_pos_t   pos;
		logic [31:0] rdata;
	} ecps_core_state_t;

	ecps_core_state_t st;
	ecps_core_state_t next_st;

	logic [5:0]  st_eff;
	logic [4:0]  turns_eff;
	logic        is_bidir;
	logic        is_sync;
	logic        comms_only;
	logic        is_marker_type;
	logic [31:0] t_bit;
	logic [31:0] t_cmd;
	logic [31:0] t_single;
	logic [31:0] t_whole;
	logic [31:0] t_sync;
	logic [31:0] t_msg;
	logic        fast_calc;
	logic        over_limit;
	logic [5:0]  pos_width;
	logic [11:0] half_cyc;
	logic [15:0] lead;
	logic        start_msg;
	logic [31:0] delta;
	logic [31:0] delta_mag;
	logic [47:0] div_num;
	logic        div_done;
	logic [47:0] div_quo;
	logic        wr_status;

	// -------------------------------------------------------------------------
	// Timing from active settings
	// -------------------------------------------------------------------------
	assign st_eff = (st.act.st_bits < ST_BITS_MIN) ? ST_BITS_MIN :
		((st.act.st_bits > ST_BITS_MAX) ? ST_BITS_MAX : st.act.st_bits);
	assign turns_eff = (st.act.turns > TURNS_MAX) ? TURNS_MAX : st.act.turns;
	assign is_bidir = (st.act.enc_type == ENC_BIDIR_COMMS_ONLY) ||
		(st.act.enc_type == ENC_SINE_COSINE_BIDIR_COMMS);
	assign is_sync = (st.act.enc_type == ENC_SYNCHRONOUS_SERIAL_ONLY) ||
		(st.act.enc_type == ENC_SINE_COSINE_WITH_SYNCHRONOUS_SERIAL);
	assign comms_only = (st.act.enc_type == ENC_BIDIR_COMMS_ONLY) ||
		(st.act.enc_type == ENC_SYNCHRONOUS_SERIAL_ONLY);
	assign is_marker_type = (st.act.enc_type <= ENC_PLAIN_SINE_COSINE);

	assign t_bit = ecps_bit_ps(st.act.rate);
	assign t_cmd = (32'(t_bit * CMD_BITS) > T_CAL_PS) ? 32'(t_bit * CMD_BITS) :
		T_CAL_PS;
	assign t_single = 32'(t_cmd + T_DATA_PS + t_bit * (BIDIR_ST_EXTRA + st_eff));
	assign t_whole = 32'(t_single + t_bit * (turns_eff + BIDIR_MSG_EXTRA));
	assign t_sync = 32'(T_DATA_PS + t_bit * (turns_eff + st_eff + SYNC_EXTRA));
	assign t_msg = is_bidir ? t_whole : t_sync;

	// Whole-microsecond round-up folds into comparing against whole-us limits
	always_comb begin
		if (is_bidir) begin
			fast_calc = (t_single <= FAST_ST_PS) && (t_whole <= FAST_MSG_PS);
		end else if (is_sync) begin
			fast_calc = (t_sync <= FAST_ST_PS);
		end else begin
			fast_calc = 1'b1;
		end
	end

	assign over_limit = comms_only && (t_msg > LIMIT_PS);

	always_comb begin
		if (st.act.rotary != 2'h0) begin
			pos_width = 6'(turns_eff) + st_eff;
		end else if (st.act.enc_type == ENC_SINE_COSINE_ASYNC_COMMS) begin
			pos_width = LINEAR_ASYNC_BITS;
		end else begin
			pos_width = st_eff;
		end
	end

	assign half_cyc = (st.act.enc_type == ENC_SINE_COSINE_ASYNC_COMMS) ? ASYNC_HALF :
		ecps_half_cyc(st.act.rate);
	assign lead = st.fast ? LEAD_FAST_CYC : LEAD_SLOW_CYC;
	assign start_msg = comms_only && (st.period > lead) && (st.since == st.period - lead);

	// -------------------------------------------------------------------------
	// Compensation divider
	// -------------------------------------------------------------------------
	assign delta = st.shreg - st.prev;
	assign delta_mag = delta[31] ? 32'(-delta) : delta;
	assign div_num = 48'(delta_mag * lead);

	ecps_div #(.NW(48), .DW(16)) u_div (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_ce   (i_ce),
		.i_go   (st.div_go),
		.i_num  (div_num),
		.i_den  (st.period),
		.o_done (div_done),
		.o_quo  (div_quo)
	);

	assign wr_status = i_wr && (i_addr == REG_STATUS);

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.div_go = 1'b0;
		next_st.pos.valid = 1'b0;
		next_st.rdata = '0;
		next_st.sy = {st.sy[1:0], i_link_data};
		if (st.sy[1] == st.sy[2]) begin
			next_st.din = st.sy[2];
		end
		if (!i_drive_enable) begin
			next_st.act = st.sw;
		end
		next_st.fast = fast_calc;

		// Datum spacing measures the sample period
		if (i_datum) begin
			next_st.period = st.since + 16'h0001;
			next_st.since = '0;
		end else if (st.since != 16'hFFFF) begin
			next_st.since = st.since + 16'h0001;
		end

		// Sticky trips, a new event beats a clear
		next_st.trip.comms_time = (st.trip.comms_time && !(wr_status &&
			i_wdata[STAT_TIME])) || over_limit;
		next_st.trip.supply_alarm = st.trip.supply_alarm && !(wr_status &&
			i_wdata[STAT_ALARM]);

		case (st.msg)
			MSG_IDLE: begin
				if (start_msg) begin
					next_st.shreg = '0;
					next_st.bits = pos_width;
					next_st.half = half_cyc;
					next_st.link_clk = 1'b0;
					next_st.msg = MSG_LOW;
				end
			end
			MSG_LOW: begin
				if (st.half <= 12'h001) begin
					next_st.link_clk = 1'b1;
					next_st.half = half_cyc;
					next_st.shreg = {st.shreg[30:0], st.din};
					next_st.bits = st.bits - 6'h01;
					next_st.msg = MSG_HIGH;
				end else begin
					next_st.half = st.half - 12'h001;
				end
			end
			MSG_HIGH: begin
				if (st.half > 12'h001) begin
					next_st.half = st.half - 12'h001;
				end else if (st.bits == 6'h00) begin
					if (is_sync && st.act.mon_en && (st.shreg[0] == ALARM_LEVEL)) begin
						next_st.trip.supply_alarm = 1'b1;
					end
					next_st.div_go = 1'b1;
					next_st.msg = MSG_COMP;
				end else begin
					next_st.link_clk = 1'b0;
					next_st.half = half_cyc;
					next_st.msg = MSG_LOW;
				end
			end
			MSG_COMP: begin
				if (div_done) begin
					next_st.pos.value = delta[31] ? st.shreg - div_quo[31:0] :
						st.shreg + div_quo[31:0];
					next_st.pos.valid = 1'b1;
					next_st.prev = st.shreg;
					next_st.msg = MSG_IDLE;
				end
			end
			default: begin
				next_st.link_clk = 1'b1;
				next_st.msg = MSG_IDLE;
			end
		endcase

		// Register writes
		if (i_wr) begin
			case (i_addr)
				REG_ST_BITS: begin
					next_st.sw.st_bits = (i_wdata[5:0] > ST_BITS_MAX) ? ST_BITS_MAX :
						i_wdata[5:0];
				end
				REG_SUPPLY: begin
					if (i_wdata[1:0] <= SUP_15V) begin
						next_st.sup = i_wdata[1:0];
					end
				end
				REG_RATE: begin
					next_st.sw.rate = i_wdata[2:0];
				end
				REG_CTRL: begin
					if (i_wdata[CTRL_TYPE_LSB +: 4] <= ENC_SYNCHRONOUS_SERIAL_ONLY) begin
						next_st.sw.enc_type = ecps_enc_t'(i_wdata[CTRL_TYPE_LSB +: 4]);
					end
					next_st.sw.mon_en = i_wdata[CTRL_MON_BIT];
					next_st.sw.rotary = i_wdata[CTRL_ROT_LSB +: 2];
					next_st.sw.auto_en = i_wdata[CTRL_AUTO_BIT];
				end
				REG_TURNS: begin
					next_st.sw.turns = i_wdata[4:0];
				end
				default: begin
				end
			endcase
		end

		// Register reads
		if (i_rd) begin
			case (i_addr)
				REG_ST_BITS: next_st.rdata = 32'(st.sw.st_bits);
				REG_SUPPLY: next_st.rdata = 32'(st.sup);
				REG_RATE: next_st.rdata = 32'(st.sw.rate);
				REG_CTRL: begin
					next_st.rdata[CTRL_TYPE_LSB +: 4] = st.sw.enc_type;
					next_st.rdata[CTRL_MON_BIT] = st.sw.mon_en;
					next_st.rdata[CTRL_ROT_LSB +: 2] = st.sw.rotary;
					next_st.rdata[CTRL_AUTO_BIT] = st.sw.auto_en;
				end
				REG_TURNS: next_st.rdata = 32'(st.sw.turns);
				REG_STATUS: begin
					next_st.rdata[STAT_FAST] = st.fast;
					next_st.rdata[STAT_TIME] = st.trip.comms_time;
					next_st.rdata[STAT_ALARM] = st.trip.supply_alarm;
					next_st.rdata[STAT_BUSY] = (st.msg != MSG_IDLE);
					next_st.rdata[STAT_WID_LSB +: 6] = pos_width;
				end
				REG_POSITION: next_st.rdata = st.pos.value;
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
			st.sw <= CFG_RST;
			st.act <= CFG_RST;
			st.sup <= SUPPLY_RST;
			st.link_clk <= 1'b1;
			st.msg <= MSG_IDLE;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign o_rdata = st.rdata;
	assign o_link_clk = st.link_clk;
	assign o_supply.v5 = (st.sup == SUP_5V);
	assign o_supply.v8 = (st.sup == SUP_8V);
	assign o_supply.v15 = (st.sup == SUP_15V);
	assign o_marker_full_reset = is_marker_type && (st.act.st_bits != 6'h00);
	assign o_fast_sampling = st.fast;
	assign o_trip = st.trip;
	assign o_pos = st.pos;
	assign o_pos_width = pos_width;

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	cfg_frozen_a: assert property (i_ce && i_drive_enable |=> $stable(st.act))
		else $error("active settings changed while drive enabled");

	st_floor_a: assert property ((st.act.st_bits == 6'h00) |-> (st_eff == 6'h01))
		else $error("zero bit count not treated as one bit");

	supply_map_a: assert property ((st.sup == SUP_8V) |-> o_supply == 3'b010)
		else $error("supply code 1 not mapped to 8V");

	marker_conv_a: assert property (i_ce && i_wr && i_addr == REG_ST_BITS &&
		i_wdata[5:0] == 6'h00 && !i_drive_enable ##1 !i_drive_enable |=> !o_marker_full_reset)
		else $error("zero bit count left full position reset on");

	async_rate_a: assert property ((st.act.enc_type == ENC_SINE_COSINE_ASYNC_COMMS)
		|-> (half_cyc == ASYNC_HALF))
		else $error("async type not at fixed rate");

	rate_default_a: assert property ($fell(i_rst) |-> st.sw.rate == 3'h2)
		else $error("rate code not at default after reset");

	time_trip_a: assert property (i_ce && over_limit |=> o_trip.comms_time)
		else $error("timing limit exceeded without trip");

	init_only_a: assert property (i_ce && !comms_only && !o_trip.comms_time &&
		!(i_wr && i_addr == REG_CTRL) |=> !o_trip.comms_time)
		else $error("timing trip raised for init-only comms");

	sync_fast_a: assert property (i_ce && is_sync && (t_sync > FAST_ST_PS)
		|=> !o_fast_sampling)
		else $error("fast sampling chosen beyond 30 us");

	msg_start_a: assert property (i_ce && st.msg == MSG_IDLE && start_msg
		|=> !o_link_clk && st.msg == MSG_LOW)
		else $error("message did not start at the lead point");

	alarm_trip_a: assert property (i_ce && st.msg == MSG_HIGH && st.half <= 12'h001 &&
		st.bits == 6'h00 && is_sync && st.act.mon_en && st.shreg[0] == ALARM_LEVEL
		|=> o_trip.supply_alarm)
		else $error("supply alarm bit not trapped");
endmodule
